// File: design/omr_pkg.sv
// Package: constants, frame layout and carriers for the output mode/reset control
package omr_pkg;
   // ------------------------------------------------------------
   // Register map (APB byte offsets)
   // ------------------------------------------------------------
   localparam logic [7:0]  CFG_OFS       = 8'h00;
   localparam logic [7:0]  STAT_OFS      = 8'h04;
   localparam logic [7:0]  WORD_OFS      = 8'h08;
   localparam logic [2:0]  CFG_ADDR_RST  = 3'h0;
   // ------------------------------------------------------------
   // Serial link and timing
   // ------------------------------------------------------------
   localparam int          FRAME_BITS    = 16;
   localparam logic [4:0]  FRAME_LEN     = 5'h10;
   localparam int          SCLK_MAX_MHZ  = 50;
   localparam int          PCLK_MHZ      = 40;
   localparam logic [1:0]  STRAP_WAIT    = 2'h2;
   // ------------------------------------------------------------
   // Range codes with voltage meaning (sense select low)
   // ------------------------------------------------------------
   localparam logic [3:0]  RNG_V5        = 4'h5;
   localparam logic [3:0]  RNG_V10       = 4'h6;
   localparam logic [3:0]  RNG_V6        = 4'h9;
   localparam logic [3:0]  RNG_V12       = 4'hA;
   localparam logic [3:0]  RNG_V40       = 4'hE;
   localparam logic [3:0]  RNG_V44       = 4'hF;

   // Control word, first bit shifted in at the top
   typedef struct packed {
      logic [2:0] addr;
      logic       rd;
      logic       z11;
      logic [3:0] range_code;
      logic       zero_level_select;
      logic       output_drive_enable;
      logic       soft_clear;
      logic       rset;
      logic       reset_bit;
      logic [1:0] z10;
   } omr_word_t;

   // Output channel controls
   typedef struct packed {
      logic       volt_drive;
      logic       volt_zero;
      logic       curr_drive;
      logic       clear_state;
      logic       zero_level;
      logic       rset;
      logic [3:0] range_code;
   } omr_drive_t;
endpackage : omr_pkg

// File: design/omr_top.sv
// Module: output mode, power-up and reset control with serial link and APB status
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - After reset the strap is sampled; mode picks the power-up conditions.
// - Software mode: zero pin high at power-up drives voltage output at 0 V.
// - Software mode: current output always powers up tristated.
// - Enable write with zero pin high enters clear state per range and zero select.
// - Hardware mode: outputs follow range pins and drive enable pin.
// - Power-on reset zeroes every register except pin synchronisers and edge detectors, which load idle levels.
// - Software mode powers up with drive enable bit at 0.
// - Software mode resets by low reset pin or reset bit; outputs disabled.
// - Reset pin is level sensitive; reset holds while pin low.
// - Reset bit clears itself after the reset command.
// - Hardware mode has no reset; reset pin held high.
// - Software mode: drive enable bit off tristates both, except the power-up zero drive of the voltage output; on enables selection.
// - Hardware mode: drive enable pin off tristates both channels.
// - Strap tied low selects software control.
// - Software control uses three-wire serial link, clock up to 50 MHz; sclk is sampled on pclk, so levels under one pclk period can be missed.
// - Current and voltage outputs are never enabled together.
// - Range from serial link in software mode, from pins in hardware mode.
// - Current ranges 0-20 mA, 0-24 mA and 4-20 mA.
// - Voltage ranges 0-5 V, 0-10 V and 0-40 V.
// - Each frame is 16 bits, MSB first, captured on falling serial clock.
module omr_top
   import omr_pkg::*;
(
   // APB
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial link
   input  wire logic        sclk,
   input  wire logic        sdin,
   input  wire logic        frame_n,
   // Pins
   input  wire logic        control_source_strap,
   input  wire logic        async_zero,
   input  wire logic        reset_pin_n,
   input  wire logic        zero_level_select,
   input  wire logic        output_drive_enable,
   input  wire logic [3:0]  range_code,
   // Output channel controls
   output omr_drive_t       drive
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   localparam int NS = 12;
   // Idle levels: clock parked high, frame and reset pins released
   localparam logic [NS-1:0] PIN_IDLE = 12'hA40;
   logic [NS-1:0] pin_a_r, pin_b_r;
   logic          sclk_d_r;
   wire  [NS-1:0] pin_raw = {sclk, sdin, frame_n, control_source_strap, async_zero,
                             reset_pin_n, zero_level_select, output_drive_enable, range_code};
   wire        sclk_s   = pin_b_r[11];
   wire        sdin_s   = pin_b_r[10];
   wire        frame_s  = pin_b_r[9];
   wire        strap_s  = pin_b_r[8];
   wire        zero_s   = pin_b_r[7];
   wire        rstpin_s = pin_b_r[6];
   wire        zsel_s   = pin_b_r[5];
   wire        en_s     = pin_b_r[4];
   wire  [3:0] rng_s    = pin_b_r[3:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_a_r  <= PIN_IDLE;
         pin_b_r  <= PIN_IDLE;
         sclk_d_r <= 1'b1;
      end else begin
         pin_a_r  <= pin_raw;
         pin_b_r  <= pin_a_r;
         sclk_d_r <= sclk_s;
      end
   end

   // ------------------------------------------------------------
   // Strap capture after reset release
   // ------------------------------------------------------------
   logic [1:0] init_cnt_r;
   logic       ready_r, mode_hw_r, pu_zero_r;
   wire        ready_nxt = !ready_r && (init_cnt_r == STRAP_WAIT);
   wire        mode_sw   = ready_r && !mode_hw_r;
   wire        mode_hw   = ready_r && mode_hw_r;

   // ------------------------------------------------------------
   // Serial receiver
   // ------------------------------------------------------------
   logic [15:0] shift_r;
   logic [4:0]  bit_cnt_r;
   logic        frame_d_r;
   logic [2:0]  dev_addr_r;
   omr_word_t   word_r;
   wire        sclk_fall = sclk_d_r && !sclk_s;
   wire        frame_end = frame_s && !frame_d_r;
   omr_word_t  rx_w;
   assign rx_w = omr_word_t'(shift_r);
   // Bits 11, 1 and 0 are not checked; host keeps them zero
   wire        exec_w = mode_sw && frame_end && bit_cnt_r == FRAME_LEN
                     && !rx_w.rd && rx_w.addr == dev_addr_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_r   <= '0;
         bit_cnt_r <= '0;
         frame_d_r <= 1'b1;
      end else begin
         frame_d_r <= frame_s;
         if (frame_s) begin
            bit_cnt_r <= '0;
         end else if (sclk_fall) begin
            shift_r   <= {shift_r[14:0], sdin_s};
            bit_cnt_r <= bit_cnt_r == 5'h1F ? bit_cnt_r : bit_cnt_r + 5'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // Control register and internal reset
   // ------------------------------------------------------------
   logic [3:0] range_r;
   logic       zsel_r, output_drive_enable_r, rset_r, sclear_r, rst_cmd_r;
   wire        pin_rst   = mode_sw && !rstpin_s;
   wire        int_rst   = pin_rst || rst_cmd_r;
   wire        wr_rst    = exec_w && rx_w.reset_bit;
   wire        wr_cfg    = exec_w && !rx_w.reset_bit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_cnt_r <= '0;
         ready_r    <= 1'b0;
         mode_hw_r  <= 1'b0;
         pu_zero_r  <= 1'b0;
         range_r    <= '0;
         zsel_r     <= 1'b0;
         output_drive_enable_r    <= 1'b0;
         rset_r     <= 1'b0;
         sclear_r   <= 1'b0;
         rst_cmd_r  <= 1'b0;
         word_r     <= '0;
      end else begin
         init_cnt_r <= ready_r ? init_cnt_r : init_cnt_r + 2'h1;
         ready_r    <= ready_r || ready_nxt;
         rst_cmd_r  <= wr_rst;
         if (exec_w) word_r <= rx_w;
         if (ready_nxt) begin
            mode_hw_r <= strap_s;
            pu_zero_r <= !strap_s && zero_s;
         end else if (int_rst) begin
            pu_zero_r <= 1'b0;
            range_r   <= '0;
            zsel_r    <= 1'b0;
            output_drive_enable_r   <= 1'b0;
            rset_r    <= 1'b0;
            sclear_r  <= 1'b0;
         end else if (wr_cfg) begin
            pu_zero_r <= pu_zero_r && !rx_w.output_drive_enable;
            range_r   <= rx_w.range_code;
            zsel_r    <= rx_w.zero_level_select;
            output_drive_enable_r   <= rx_w.output_drive_enable;
            rset_r    <= rx_w.rset;
            sclear_r  <= rx_w.soft_clear;
         end
      end
   end

   // ------------------------------------------------------------
   // Output channel selection
   // ------------------------------------------------------------
   function automatic logic is_volt(input logic [3:0] rc, input logic rs);
      is_volt = !rs && (rc == RNG_V5 || rc == RNG_V10 || rc == RNG_V6 ||
                        rc == RNG_V12 || rc == RNG_V40 || rc == RNG_V44);
   endfunction : is_volt

   wire  [3:0] sel_rng = mode_hw ? rng_s : range_r;
   wire        sel_rs  = mode_hw ? 1'b0 : rset_r;
   wire        sel_en  = mode_hw ? en_s : (mode_sw && output_drive_enable_r);
   wire        sel_v   = is_volt(sel_rng, sel_rs);
   wire        clr_act = sel_en && (zero_s || (mode_sw && sclear_r));
   omr_drive_t drive_nxt;
   assign drive_nxt.volt_drive  = (sel_en && sel_v) || (mode_sw && pu_zero_r);
   assign drive_nxt.volt_zero   = mode_sw && pu_zero_r && !sel_en;
   assign drive_nxt.curr_drive  = sel_en && !sel_v;
   assign drive_nxt.clear_state = clr_act;
   assign drive_nxt.zero_level  = mode_hw ? zsel_s : (zsel_r || zsel_s);
   assign drive_nxt.rset        = sel_rs;
   assign drive_nxt.range_code  = sel_rng;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) drive <= '0;
      else          drive <= drive_nxt;
   end

   // ------------------------------------------------------------
   // APB slave, one wait state
   // ------------------------------------------------------------
   wire        acc     = psel && penable && !pready;
   wire        commit  = psel && penable && pready;
   wire        hit_cfg = paddr == CFG_OFS;
   wire        hit_st  = paddr == STAT_OFS;
   wire        hit_wd  = paddr == WORD_OFS;
   wire        bad     = !(hit_cfg || hit_st || hit_wd);
   wire [31:0] stat_w  = {20'h0, drive_nxt.range_code, rst_cmd_r, pu_zero_r,
                          output_drive_enable_r, drive.clear_state, drive.curr_drive,
                          drive.volt_drive, mode_hw_r, ready_r};
   wire [31:0] rd_w    = hit_cfg ? {29'h0, dev_addr_r} :
                         hit_st  ? stat_w :
                         hit_wd  ? {16'h0, word_r} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         prdata     <= '0;
         dev_addr_r <= CFG_ADDR_RST;
      end else begin
         pready  <= acc;
         pslverr <= acc && bad;
         prdata  <= (acc && !pwrite) ? rd_w : 32'h0;
         if (commit && pwrite && hit_cfg) dev_addr_r <= pwdata[2:0];
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_frame_ok;
      frame_end && bit_cnt_r == FRAME_LEN;
   endsequence
   sequence s_enable_write;
      exec_w && !rx_w.reset_bit && rx_w.output_drive_enable && !int_rst;
   endsequence

   a_one_channel: assert property (@(posedge pclk) disable iff (!presetn)
      !(drive.volt_drive && drive.curr_drive)) else $error("both channels driven");
   a_frame_store: assert property (@(posedge pclk) disable iff (!presetn)
      s_frame_ok and exec_w |=> word_r == $past(shift_r)) else $error("frame not stored");
   a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
      s_enable_write ##1 !int_rst |-> output_drive_enable_r ##1 (drive.curr_drive == !is_volt(range_r, rset_r)))
      else $error("enable write lost");
   a_enable_range: assert property (@(posedge pclk) disable iff (!presetn)
      s_enable_write and !pin_rst |=> range_r == $past(rx_w.range_code)) else $error("range not taken");
   a_pin_reset: assert property (@(posedge pclk) disable iff (!presetn)
      pin_rst [*3] |-> !drive.curr_drive && !drive.volt_drive && !output_drive_enable_r) else $error("reset pin ignored");
   a_reset_bit: assert property (@(posedge pclk) disable iff (!presetn)
      wr_rst |=> rst_cmd_r ##1 (!rst_cmd_r && !output_drive_enable_r)) else $error("reset bit stuck");
   a_hw_disable: assert property (@(posedge pclk) disable iff (!presetn)
      mode_hw && !en_s |=> !drive.curr_drive && !drive.volt_drive) else $error("hw disable failed");
   a_clear_state: assert property (@(posedge pclk) disable iff (!presetn)
      mode_sw && output_drive_enable_r && zero_s |=> drive.clear_state) else $error("clear state missed");
   a_power_up: assert property (@(posedge pclk) disable iff (!presetn)
      ready_nxt && !strap_s |=> pu_zero_r == $past(zero_s) && !output_drive_enable_r) else $error("power-up state wrong");
   a_curr_off_pu: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ready_r) && !mode_hw_r |=> !drive.curr_drive) else $error("current on at power-up");

   // ------------------------------------------------------------
   // Assertions: power-up and mode
   // ------------------------------------------------------------
   sequence s_sw_power_up;
      ready_nxt && !strap_s;
   endsequence

   a_strap_mode: assert property (@(posedge pclk) disable iff (!presetn)
      ready_nxt |=> mode_hw_r == $past(strap_s))
      else $error("strap not captured");

   a_sw_strap: assert property (@(posedge pclk) disable iff (!presetn)
      s_sw_power_up |=> mode_sw)
      else $error("software mode not entered");

   a_pu_tristate: assert property (@(posedge pclk) disable iff (!presetn)
      s_sw_power_up ##0 !zero_s |=> ##1 (!drive.volt_drive && !drive.curr_drive))
      else $error("voltage output not tristated");

   a_pu_zero_drive: assert property (@(posedge pclk) disable iff (!presetn)
      s_sw_power_up ##0 zero_s |=> ##1 (drive.volt_drive && drive.volt_zero))
      else $error("zero drive missing at power-up");

   a_output_drive_enable_pu: assert property (@(posedge pclk) disable iff (!presetn)
      ready_nxt |=> !output_drive_enable_r)
      else $error("drive enable set at power-up");

   a_regs_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !ready_r |-> (range_r == 4'h0 && !output_drive_enable_r && !pu_zero_r && !rset_r))
      else $error("register not zero");

   a_drive_early: assert property (@(posedge pclk) disable iff (!presetn)
      !ready_r |=> (!drive.volt_drive && !drive.curr_drive && !drive.clear_state))
      else $error("output active before ready");

   // ------------------------------------------------------------
   // Assertions: reset paths and end of power-up zero drive
   // ------------------------------------------------------------
   a_reset_clears: assert property (@(posedge pclk) disable iff (!presetn)
      int_rst |=> (!output_drive_enable_r && !pu_zero_r && range_r == 4'h0 && !sclear_r))
      else $error("internal reset left state");

   a_reset_drive: assert property (@(posedge pclk) disable iff (!presetn)
      int_rst |=> ##1 (!drive.volt_drive && !drive.curr_drive))
      else $error("outputs not disabled by reset");

   a_hw_no_reset: assert property (@(posedge pclk) disable iff (!presetn)
      mode_hw |-> !int_rst)
      else $error("reset acted in hardware mode");

   a_cmd_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      rst_cmd_r |=> !rst_cmd_r)
      else $error("reset bit held");

   a_pu_zero_end: assert property (@(posedge pclk) disable iff (!presetn)
      s_enable_write |=> !pu_zero_r)
      else $error("zero drive not ended");

   // ------------------------------------------------------------
   // Assertions: channel selection
   // ------------------------------------------------------------
   sequence s_sw_enabled;
      mode_sw && output_drive_enable_r;
   endsequence

   sequence s_hw_enabled;
      mode_hw && en_s;
   endsequence

   a_sw_disable: assert property (@(posedge pclk) disable iff (!presetn)
      mode_sw && !output_drive_enable_r |=> (!drive.curr_drive && !drive.clear_state))
      else $error("disabled channel active");

   a_sw_current: assert property (@(posedge pclk) disable iff (!presetn)
      s_sw_enabled ##0 !is_volt(range_r, rset_r) |=> (drive.curr_drive && !drive.volt_drive))
      else $error("current range not driven");

   a_sw_voltage: assert property (@(posedge pclk) disable iff (!presetn)
      s_sw_enabled ##0 is_volt(range_r, rset_r) |=> (drive.volt_drive && !drive.curr_drive))
      else $error("voltage range not driven");

   a_hw_enable: assert property (@(posedge pclk) disable iff (!presetn)
      s_hw_enabled ##0 is_volt(rng_s, 1'b0) |=> (drive.volt_drive && !drive.curr_drive))
      else $error("pin voltage range not driven");

   a_hw_range: assert property (@(posedge pclk) disable iff (!presetn)
      mode_hw |=> drive.range_code == $past(rng_s))
      else $error("range pins not followed");

   a_sw_range: assert property (@(posedge pclk) disable iff (!presetn)
      mode_sw |=> drive.range_code == $past(range_r))
      else $error("range register not followed");

   a_clear_level: assert property (@(posedge pclk) disable iff (!presetn)
      s_sw_enabled ##0 zero_s |=> drive.zero_level == $past(zsel_r || zsel_s))
      else $error("clear level wrong");

   // ------------------------------------------------------------
   // Assertions: serial link
   // ------------------------------------------------------------
   a_frame_idle: assert property (@(posedge pclk) disable iff (!presetn)
      frame_s |=> bit_cnt_r == 5'h00)
      else $error("bit count not cleared");

   a_shift_fall: assert property (@(posedge pclk) disable iff (!presetn)
      !frame_s && sclk_fall |=> shift_r[0] == $past(sdin_s))
      else $error("bit not shifted");

   a_hw_ignore: assert property (@(posedge pclk) disable iff (!presetn)
      mode_hw |=> word_r == $past(word_r))
      else $error("frame taken in hardware mode");
endmodule : omr_top

// File: dv/omr_host_model.sv
// Host side of the three-wire serial link
`timescale 1ns/1ps
module omr_host_model (
   // Serial link
   output logic sclk,
   output logic sdin,
   output logic frame_n
);
   // ----------------------------------------
   // Idle: clock parked high, frame closed
   // ----------------------------------------
   initial begin
      sclk    = 1'b1;
      sdin    = 1'b0;
      frame_n = 1'b1;
   end

   // ----------------------------------------
   // One control word, top bit first
   // ----------------------------------------
   task automatic send_word(input logic [15:0] w);
      frame_n = 1'b0;
      #100;
      for (int i = 15; i >= 0; i--) begin
         sdin = w[i];
         #100 sclk = 1'b0;
         #100 sclk = 1'b1;
      end
      #100 frame_n = 1'b1;
      // Released line shows no stale bit
      sdin = ~sdin;
      #600;
   endtask : send_word
endmodule : omr_host_model

// File: dv/omr_top_bench.sv
// Testbench: output mode, power-up and reset control
`timescale 1ns/1ps
module omr_top_bench;
   import omr_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        sclk, sdin, frame_n, strap, az, rst_n, zsel, oen;
   logic [3:0]  rng;
   omr_drive_t  drive;
   int          n_fail, checks_done;

   omr_top u_omr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
      .sdin(sdin), .frame_n(frame_n), .control_source_strap(strap), .async_zero(az), .reset_pin_n(rst_n),
      .zero_level_select(zsel), .output_drive_enable(oen), .range_code(rng), .drive(drive));
   omr_host_model u_omr_host_model (.sclk(sclk), .sdin(sdin), .frame_n(frame_n));

   // ----------------------------------------
   // Clock, time-zero values, watchdog
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, strap, az, zsel, oen} = 8'h00;
      {paddr, pwdata, rng} = 44'h0;
      rst_n = 1'b1;
   end
   initial begin
      #400us;
      n_fail++;
      tally_and_finish();
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (k == 16) chk(32'(pready), 32'h1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [15:0] cw(input logic [3:0] r, input logic en, input logic rs);
      return {3'h0, 1'b0, 1'b0, r, 1'b0, en, 1'b0, 1'b0, rs, 2'b00};
   endfunction : cw
   task automatic send(input logic [15:0] w);
      u_omr_host_model.send_word(w);
      repeat (8) @(posedge pclk);
   endtask : send
   task automatic do_reset(input logic s, input logic z);
      int k;
      @(posedge pclk);
      presetn <= 1'b0;
      strap   <= s;
      az      <= z;
      repeat (2) @(posedge pclk);
      chk(32'(drive), 32'h0);
      presetn <= 1'b1;
      k = 0;
      do begin
         apb(1'b0, STAT_OFS, 32'h0);
         k++;
      end while (rd[0] !== 1'b1 && k < 20);
      chk(32'(rd[1]), 32'(s));
   endtask : do_reset

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_powerup();
      do_reset(1'b0, 1'b0);
      apb(1'b0, CFG_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, STAT_OFS, 32'h0);
      chk(32'(rd[5]), 32'h0);
      chk(32'({drive.volt_zero, drive.curr_drive}), 32'h0);
      zsel <= 1'b1;
      do_reset(1'b0, 1'b1);
      chk(32'(drive.volt_zero), 32'h1);
      chk(32'(drive.curr_drive), 32'h0);
      send(cw(RNG_V10, 1'b1, 1'b0));
      chk(32'({drive.clear_state, drive.zero_level}), 32'h3);
      chk(32'(drive.range_code), 32'(RNG_V10));
      az <= 1'b0;
      repeat (8) @(posedge pclk);
      chk(32'({drive.clear_state, drive.volt_drive, drive.volt_zero}), 32'h2);
   endtask : t_powerup
   task automatic t_apb();
      apb(1'b1, CFG_OFS, 32'h5);
      apb(1'b0, CFG_OFS, 32'h0);
      chk(rd, 32'h5);
      apb(1'b0, 8'h40, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      send(cw(4'h1, 1'b1, 1'b0));
      chk(32'(drive.range_code), 32'(RNG_V10));
      apb(1'b0, WORD_OFS, 32'h0);
      chk(rd, {16'h0, cw(RNG_V10, 1'b1, 1'b0)});
      apb(1'b1, CFG_OFS, 32'h0);
   endtask : t_apb
   task automatic t_ranges();
      logic [3:0] tab[6] = '{4'h0, 4'h1, 4'h2, RNG_V5, RNG_V10, RNG_V40};
      zsel <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         send(cw(tab[i], 1'b0, 1'b0));
         chk(32'({drive.volt_drive, drive.curr_drive}), 32'h0);
         send(cw(tab[i], 1'b1, 1'b0));
         chk(32'({drive.volt_drive, drive.curr_drive}), (i > 2) ? 32'h2 : 32'h1);
         chk(32'(drive.range_code), 32'(tab[i]));
      end
      send(cw(RNG_V5, 1'b0, 1'b0) | 16'h0008);
      send(cw(RNG_V5, 1'b1, 1'b0) | 16'h0008);
      chk(32'({drive.volt_drive, drive.curr_drive, drive.rset}), 32'h3);
      send(cw(RNG_V5, 1'b0, 1'b0));
      send(cw(RNG_V5, 1'b1, 1'b0) | 16'h0050);
      chk(32'({drive.clear_state, drive.volt_drive, drive.zero_level}), 32'h7);
   endtask : t_ranges
   task automatic t_reset();
      send(cw(RNG_V40, 1'b1, 1'b1));
      chk(32'({drive.volt_drive, drive.curr_drive}), 32'h0);
      apb(1'b0, STAT_OFS, 32'h0);
      chk(32'({rd[7], rd[5]}), 32'h0);
      send(cw(4'h1, 1'b1, 1'b0));
      chk(32'(drive.curr_drive), 32'h1);
      rst_n <= 1'b0;
      repeat (6) @(posedge pclk);
      chk(32'(drive.curr_drive), 32'h0);
      send(cw(4'h1, 1'b1, 1'b0));
      chk(32'(drive.curr_drive), 32'h0);
      rst_n <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(32'({drive.volt_drive, drive.curr_drive}), 32'h0);
   endtask : t_reset
   task automatic t_hw();
      rng <= RNG_V5;
      do_reset(1'b1, 1'b0);
      chk(32'({drive.volt_drive, drive.curr_drive}), 32'h0);
      oen <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(32'({drive.volt_drive, drive.curr_drive}), 32'h2);
      chk(32'(drive.range_code), 32'(RNG_V5));
      oen <= 1'b0;
      rng <= 4'h2;
      repeat (8) @(posedge pclk);
      chk(32'({drive.volt_drive, drive.curr_drive}), 32'h0);
      oen <= 1'b1;
      rst_n <= 1'b0;
      repeat (8) @(posedge pclk);
      chk(32'({drive.volt_drive, drive.curr_drive}), 32'h1);
      rst_n <= 1'b1;
      send(cw(RNG_V10, 1'b1, 1'b0));
      chk(32'(drive.range_code), 32'h2);
   endtask : t_hw

   // ----------------------------------------
   // Main sequence and verdict
   // ----------------------------------------
   task automatic tally_and_finish();
      if (n_fail == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      t_powerup();
      t_apb();
      t_ranges();
      t_reset();
      t_hw();
      tally_and_finish();
   end
endmodule : omr_top_bench
